/* common/adc_ctrl_pkg.sv */
// package: register map, field layout, timing and bus types of the converter control
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 6;
  localparam logic [5:0] OFS_CTRL        = 6'h00;
  localparam logic [5:0] OFS_PORT        = 6'h04;
  localparam logic [5:0] OFS_TIMING      = 6'h08;
  localparam logic [5:0] OFS_RES_HIGH    = 6'h0C;
  localparam logic [5:0] OFS_RES_LOW     = 6'h10;
  localparam logic [5:0] OFS_STATUS      = 6'h14;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CHAN_RST        = 4'h0;
  localparam logic [5:0] PORT_RST        = 6'h00;
  localparam logic [7:0] TIMING_RST      = 8'h00;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int CHAN_W        = 4;
  localparam int PORT_W        = 6;
  localparam int TIM_FMT_BIT   = 7;
  localparam int TIM_ACQ_LSB   = 3;
  localparam int TIM_CLK_LSB   = 0;
  localparam int SEL_W         = 3;
  localparam int STAT_FLAG_BIT = 0;
  localparam int RES_W         = 10;
  localparam int BYTE_W        = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 25;
  localparam int INSTR_CYCLE_NS    = 100;
  localparam int INSTR_CYCLE_CLKS  = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TADS         = 11;

  // system clock divisor per clock select code; the two rc codes never use it
  localparam logic [6:0] CLK_DIV_TABLE [8] = '{7'h02, 7'h08, 7'h20, 7'h02,
                                               7'h04, 7'h10, 7'h40, 7'h02};
  // programmed acquisition length in conversion-bit periods per code
  localparam logic [4:0] ACQ_TAD_TABLE [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                               5'h08, 5'h0C, 5'h10, 5'h14};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ACQ, ST_CONV} conv_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage : adc_ctrl_pkg

/* logic/adc_pin_sync.sv */
// module: three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
module adc_pin_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic [2:0] stage;
  wire        agree = (stage[2] == stage[1]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= {stage[1:0], pin};
      if (agree) begin
        level <= stage[1];
      end
    end
  end

  assign rise = agree & stage[1] & ~level;

endmodule : adc_pin_sync

/* logic/adc_tad_gen.sv */
// module: conversion-bit period tick from a system clock divider or the rc oscillator
`timescale 1ns/100ps
module adc_tad_gen (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  input  wire logic       rc_rise,
  output logic            tad_tick
);
  import adc_ctrl_pkg::*;

  logic [5:0] cnt;
  wire  [6:0] div    = CLK_DIV_TABLE[clk_sel];
  wire        use_rc = (clk_sel[1:0] == 2'h3);
  wire        wrap   = (cnt == 6'(div - 7'h01));

  // counter held at zero while idle so every divider-clocked acquisition starts on a full period; the rc codes tick on rc_rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
    end else if (!run || wrap) begin
      cnt <= 6'h00;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end

  assign tad_tick = run & (use_rc ? rc_rise : wrap);

endmodule : adc_tad_gen

/* logic/adc_acq_conv_ctrl.sv */
// module: acquisition and conversion control of the 10-bit converter, AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module adc_acq_conv_ctrl (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire adc_ctrl_pkg::axil_req_t axi_req,
  output adc_ctrl_pkg::axil_rsp_t      axi_rsp,
  input  wire logic                    rc_osc_pin,
  input  wire logic                    comp_above,
  output logic [3:0]                   channel_select,
  output logic [5:0]                   port_config,
  output logic                         converter_enable,
  output logic                         sample_enable,
  output logic [9:0]                   dac_code,
  output logic                         conversion_complete_flag
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  conv_state_t       state;
  conv_state_t       next_state;
  logic [4:0]        phase_cnt;
  logic [4:0]        next_phase_cnt;
  logic              done;

  logic              enable;
  logic [CHAN_W-1:0] channel;
  logic [PORT_W-1:0] port_cfg;
  logic              result_format_select;
  logic [SEL_W-1:0]  acquisition_time_select;
  logic [SEL_W-1:0]  conversion_clock_select;
  logic              flag;
  logic [BYTE_W-1:0] result_high_byte;
  logic [BYTE_W-1:0] result_low_byte;
  logic [RES_W-1:0]  sar;

  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic              w_lane0;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;

  logic              rc_level;
  logic              rc_rise;
  logic              tad_tick;

  // ----------------------------------------------------------------
  // rc oscillator and bit-period generator
  // ----------------------------------------------------------------
  adc_pin_sync u_rc_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin     (rc_osc_pin),
    .level   (rc_level),
    .rise    (rc_rise)
  );

  wire tad_run = (state == ST_ACQ) || (state == ST_CONV);

  adc_tad_gen u_tad_gen (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .run      (tad_run),
    .clk_sel  (conversion_clock_select),
    .rc_rise  (rc_rise),
    .tad_tick (tad_tick)
  );

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  wire wr_go = aw_full & w_full & ~bvalid;
  wire rd_go = axi_req.arvalid & ~rvalid;

  wire hit_ctrl   = (aw_addr == OFS_CTRL);
  wire hit_port   = (aw_addr == OFS_PORT);
  wire hit_timing = (aw_addr == OFS_TIMING);
  wire hit_high   = (aw_addr == OFS_RES_HIGH);
  wire hit_low    = (aw_addr == OFS_RES_LOW);
  wire hit_status = (aw_addr == OFS_STATUS);
  wire wr_mapped  = hit_ctrl | hit_port | hit_timing | hit_high | hit_low | hit_status;

  // writes that miss byte lane 0 leave every register alone
  wire wr_lane    = wr_go & w_lane0;
  wire wr_ctrl    = wr_lane & hit_ctrl;
  wire wr_port    = wr_lane & hit_port;
  wire wr_timing  = wr_lane & hit_timing;
  wire wr_high    = wr_lane & hit_high;
  wire wr_low     = wr_lane & hit_low;
  wire wr_status  = wr_lane & hit_status;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end else if (axi_req.awvalid && !aw_full) begin
      aw_full <= 1'b1;
      aw_addr <= axi_req.awaddr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else if (wr_go) begin
      w_full  <= 1'b0;
    end else if (axi_req.wvalid && !w_full) begin
      w_full  <= 1'b1;
      w_data  <= axi_req.wdata;
      w_lane0 <= axi_req.wstrb[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire busy = (state != ST_IDLE);

  wire [BYTE_W-1:0] ctrl_rd   = {2'h0, channel, busy, enable};
  wire [BYTE_W-1:0] port_rd   = {2'h0, port_cfg};
  wire [BYTE_W-1:0] timing_rd = {result_format_select, 1'b0,
                                 acquisition_time_select,
                                 conversion_clock_select};
  wire [BYTE_W-1:0] status_rd = {7'h00, flag};

  wire [ADDR_W-1:0] ra = axi_req.araddr;
  wire rd_mapped = (ra == OFS_CTRL) | (ra == OFS_PORT) | (ra == OFS_TIMING) |
                   (ra == OFS_RES_HIGH) | (ra == OFS_RES_LOW) | (ra == OFS_STATUS);

  wire [BYTE_W-1:0] rd_byte = (ra == OFS_CTRL)     ? ctrl_rd :
                              (ra == OFS_PORT)     ? port_rd :
                              (ra == OFS_TIMING)   ? timing_rd :
                              (ra == OFS_RES_HIGH) ? result_high_byte :
                              (ra == OFS_RES_LOW)  ? result_low_byte :
                              (ra == OFS_STATUS)   ? status_rd : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_byte};
      rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.rready) begin
      rvalid <= 1'b0;
    end
  end

  assign axi_rsp = '{awready: ~aw_full,
                     wready:  ~w_full,
                     bvalid:  bvalid,
                     bresp:   bresp,
                     arready: ~rvalid,
                     rvalid:  rvalid,
                     rdata:   rdata,
                     rresp:   rresp};

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  wire go_bit = w_data[CTRL_GO_BIT];
  wire en_bit = w_data[CTRL_EN_BIT];

  // a start written with the enable bit clear is dropped; a start while busy just keeps it going
  wire start_req = wr_ctrl & go_bit & en_bit & ~busy;
  // clearing the start bit or the enable while busy abandons the conversion
  wire abort_req = wr_ctrl & busy & ~(go_bit & en_bit);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable                  <= 1'b0;
      channel                 <= CHAN_RST;
      port_cfg                <= PORT_RST;
      result_format_select    <= TIMING_RST[TIM_FMT_BIT];
      acquisition_time_select <= TIMING_RST[TIM_ACQ_LSB +: SEL_W];
      conversion_clock_select <= TIMING_RST[TIM_CLK_LSB +: SEL_W];
    end else begin
      if (wr_ctrl) begin
        enable  <= en_bit;
        channel <= w_data[CTRL_CHAN_LSB +: CHAN_W];
      end
      if (wr_port) begin
        port_cfg <= w_data[PORT_W-1:0];
      end
      if (wr_timing) begin
        result_format_select    <= w_data[TIM_FMT_BIT];
        acquisition_time_select <= w_data[TIM_ACQ_LSB +: SEL_W];
        conversion_clock_select <= w_data[TIM_CLK_LSB +: SEL_W];
      end
    end
  end

  // completion beats a software clear landing in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (done) begin
      flag <= 1'b1;
    end else if (wr_status && w_data[STAT_FLAG_BIT]) begin
      flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire       use_rc   = (conversion_clock_select[1:0] == 2'h3);
  wire [4:0] acq_tads = ACQ_TAD_TABLE[acquisition_time_select];
  wire       acq_none = (acq_tads == 5'h00);

  always_comb begin
    next_state     = state;
    next_phase_cnt = phase_cnt;
    done           = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_phase_cnt = 5'h00;
          if (use_rc) begin
            next_state = ST_DELAY;
          end else if (acq_none) begin
            next_state = ST_CONV;
          end else begin
            next_state = ST_ACQ;
          end
        end
      end
      ST_DELAY: begin
        if (phase_cnt == 5'(INSTR_CYCLE_CLKS - 1)) begin
          next_phase_cnt = 5'h00;
          next_state     = acq_none ? ST_CONV : ST_ACQ;
        end else begin
          next_phase_cnt = phase_cnt + 5'h01;
        end
      end
      ST_ACQ: begin
        if (tad_tick) begin
          if (phase_cnt == acq_tads - 5'h01) begin
            next_phase_cnt = 5'h00;
            next_state     = ST_CONV;
          end else begin
            next_phase_cnt = phase_cnt + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (tad_tick) begin
          if (phase_cnt == 5'(CONV_TADS - 1)) begin
            next_phase_cnt = 5'h00;
            next_state     = ST_IDLE;
            done           = 1'b1;
          end else begin
            next_phase_cnt = phase_cnt + 5'h01;
          end
        end
      end
      default: begin
        next_state     = ST_IDLE;
        next_phase_cnt = 5'h00;
      end
    endcase
    if (abort_req) begin
      next_state     = ST_IDLE;
      next_phase_cnt = 5'h00;
      done           = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      phase_cnt <= 5'h00;
    end else begin
      state     <= next_state;
      phase_cnt <= next_phase_cnt;
    end
  end

  // ----------------------------------------------------------------
  // successive approximation
  // ----------------------------------------------------------------
  // period 0 loads the midscale trial; period k settles bit RES_W-k and tries the next
  wire sar_step  = (state == ST_CONV) & tad_tick;
  wire sar_clear = sar_step & (phase_cnt == 5'h00);

  for (genvar i = 0; i < RES_W; i++) begin : g_sar
    wire trial  = sar_step & (phase_cnt == 5'(RES_W - 1 - i));
    wire decide = sar_step & (phase_cnt == 5'(RES_W - i));
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        sar[i] <= 1'b0;
      end else if (trial) begin
        sar[i] <= 1'b1;
      end else if (sar_clear || (decide && !comp_above)) begin
        sar[i] <= 1'b0;
      end
    end
  end

  // the lsb is settled in the same period that completes, so fold it in here
  wire [RES_W-1:0] final_code = {sar[RES_W-1:1], sar[0] & comp_above};

  wire [BYTE_W-1:0] right_high = {6'h00, final_code[9:8]};
  wire [BYTE_W-1:0] right_low  = final_code[7:0];
  wire [BYTE_W-1:0] left_high  = final_code[9:2];
  wire [BYTE_W-1:0] left_low   = {final_code[1:0], 6'h00};

  // ----------------------------------------------------------------
  // result pair
  // ----------------------------------------------------------------
  // no reset on purpose: the pair keeps whatever it holds across a reset
  always_ff @(posedge sys_clk) begin
    if (done) begin
      result_high_byte <= result_format_select ? right_high : left_high;
      result_low_byte  <= result_format_select ? right_low : left_low;
    end else begin
      if (wr_high) begin
        result_high_byte <= w_data[BYTE_W-1:0];
      end
      if (wr_low) begin
        result_low_byte <= w_data[BYTE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // analog front end
  // ----------------------------------------------------------------
  // sampling runs whenever enabled and not converting, so acquisition resumes after done
  assign sample_enable            = enable & (state != ST_CONV);
  assign dac_code                 = sar;
  assign channel_select           = channel;
  assign port_config              = port_cfg;
  assign converter_enable         = enable;
  assign conversion_complete_flag = flag;

endmodule : adc_acq_conv_ctrl

/* test/adc_acq_conv_ctrl_asserts.sv */
// checker: port-level properties of the converter control
`timescale 1ns/100ps
module adc_acq_conv_ctrl_chk (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire adc_ctrl_pkg::axil_req_t axi_req,
  input wire adc_ctrl_pkg::axil_rsp_t axi_rsp,
  input wire logic                    rc_osc_pin,
  input wire logic                    comp_above,
  input wire logic [3:0]              channel_select,
  input wire logic [5:0]              port_config,
  input wire logic                    converter_enable,
  input wire logic                    sample_enable,
  input wire logic [9:0]              dac_code,
  input wire logic                    conversion_complete_flag
);
  import adc_ctrl_pkg::*;
  // ------------------------------------------------
  // cycles with the holding capacitor disconnected
  // ------------------------------------------------
  logic [11:0] low_cnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 12'h000;
    else if (sample_enable) low_cnt <= 12'h000;
    else if (low_cnt != 12'hFFF) low_cnt <= low_cnt + 12'h001;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_sample_en; sample_enable |-> converter_enable; endproperty
  a_sample_en: assert property (p_sample_en) else $error("sampling while disabled");
  property p_done_resume; $rose(conversion_complete_flag) |-> !$past(sample_enable) && sample_enable; endproperty
  a_done_resume: assert property (p_done_resume) else $error("done without resumed sampling");
  property p_conv_len; $rose(conversion_complete_flag) |-> low_cnt >= 12'h016; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");
  property p_flag_clear; $fell(conversion_complete_flag) |-> $rose(axi_rsp.bvalid); endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without a write");
  property p_chan_write; $changed(channel_select) |-> $rose(axi_rsp.bvalid); endproperty
  a_chan_write: assert property (p_chan_write) else $error("channel changed without a write");
  property p_en_write; $changed(converter_enable) |-> $rose(axi_rsp.bvalid); endproperty
  a_en_write: assert property (p_en_write) else $error("enable changed without a write");
  property p_bit6; $rose(axi_rsp.rvalid) && $past(axi_req.araddr) == OFS_TIMING |-> axi_rsp.rdata[31:6] == 26'h0
    || (axi_rsp.rdata[31:8] == 24'h0 && !axi_rsp.rdata[6]); endproperty
  a_bit6: assert property (p_bit6) else $error("timing bit 6 reads one");
  property p_ar_answer; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read not answered");

  c_done: cover property ($rose(conversion_complete_flag));
  c_conv: cover property ($fell(sample_enable) && converter_enable);
  c_clear: cover property ($fell(conversion_complete_flag));
endmodule : adc_acq_conv_ctrl_chk

bind adc_acq_conv_ctrl adc_acq_conv_ctrl_chk u_chk (.sys_clk, .rst_n, .axi_req, .axi_rsp, .rc_osc_pin,
  .comp_above, .channel_select, .port_config, .converter_enable, .sample_enable, .dac_code,
  .conversion_complete_flag);

/* test/test_adc_acq_conv_ctrl.sv */
// testbench: bus-level scenarios for the converter control
`timescale 1ns/100ps
module test_adc_acq_conv_ctrl;
  import adc_ctrl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  axil_req_t   axi_req = '0;
  axil_rsp_t   axi_rsp;
  logic        rc_osc_pin = 1'b0;
  logic        comp_above = 1'b0;
  logic [3:0]  channel_select;
  logic [5:0]  port_config;
  logic        converter_enable;
  logic        sample_enable;
  logic [9:0]  dac_code;
  logic        conversion_complete_flag;
  logic [9:0]  target = 10'h000;
  logic [3:0]  rc_cnt = 4'h0;
  logic [31:0] rd;
  logic [31:0] prev;
  logic [1:0]  rs;
  int          err_total = 0;
  int          total_checks = 0;
  int          dv [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int          aq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  logic [9:0]  tg [8] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA, 10'h001, 10'h200, 10'h1FF, 10'h37C};

  always #12.5 sys_clk = ~sys_clk;

  // rc oscillator runs free at a tenth of the system clock; comparator lags one clock,
  // which the fastest tick spacing of two clocks still tolerates
  always @(posedge sys_clk) begin
    rc_cnt     <= (rc_cnt == 4'h9) ? 4'h0 : rc_cnt + 4'h1;
    rc_osc_pin <= (rc_cnt >= 4'h5);
    comp_above <= (target >= dac_code);
  end

  adc_acq_conv_ctrl dut (.sys_clk, .rst_n, .axi_req, .axi_rsp, .rc_osc_pin, .comp_above, .channel_select,
    .port_config, .converter_enable, .sample_enable, .dac_code, .conversion_complete_flag);

  // ------------------------------------------------
  // reporting and bus tasks
  // ------------------------------------------------
  task stop_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task bound(input int n);
    if (n > 3000) begin
      err_total++;
      stop_test();
    end
  endtask : bound

  task wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      bound(n);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    rs = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : wr

  task rd_reg(input logic [5:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      bound(n);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    rd = axi_rsp.rdata;
    rs = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : rd_reg

  task rchk(input logic [5:0] a, input logic [31:0] e);
    rd_reg(a);
    chk(rd, e);
  endtask : rchk

  // one conversion; t counts clocks after the start write is answered
  task conv(input logic [7:0] tim, input logic [3:0] ch);
    int t;
    int ta;
    int tc;
    int n;
    int a;
    t = 0;
    ta = -1;
    tc = 0;
    n = dv[tim[2:0]];
    a = aq[tim[5:3]];
    wr(OFS_TIMING, {24'h0, tim});
    wr(OFS_CTRL, {26'h0, ch, 2'b01});
    chk(channel_select, ch);
    // channel settles and the last conversion rests at least three bit periods before the start
    repeat ((n > 0) ? 3 * n : 40) @(posedge sys_clk);
    wr(OFS_CTRL, {26'h0, ch, 2'b11});
    do begin
      if (!sample_enable) begin
        if (ta < 0) ta = t;
        tc++;
      end
      @(posedge sys_clk);
      t++;
      bound(t);
    end while (conversion_complete_flag !== 1'b1);
    if (n > 0) begin
      chk(tc, 11 * n);
      chk(ta >= a * n && ta <= a * n + 4, 1);
    end else begin
      chk(tc >= 100 && tc <= 112, 1);
      chk(ta >= 3, 1);
    end
    rchk(OFS_CTRL, {26'h0, ch, 2'b01});
    rchk(OFS_RES_HIGH, tim[7] ? {30'h0, target[9:8]} : {24'h0, target[9:2]});
    rchk(OFS_RES_LOW, tim[7] ? {24'h0, target[7:0]} : {24'h0, target[1:0], 6'h00});
    rchk(OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    rchk(OFS_STATUS, 32'h0);
  endtask : conv

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(OFS_TIMING, 32'h0);
    rchk(OFS_CTRL, 32'h0);
    wr(OFS_TIMING, 32'hFF);
    rchk(OFS_TIMING, 32'hBF);
    rd_reg(6'h18);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(6'h18, 32'h1);
    chk(rs, RESP_SLVERR);
    wr(OFS_PORT, 32'h2A);
    chk(rs, RESP_OKAY);
    chk(port_config, 6'h2A);
    for (int i = 0; i < 8; i++) begin
      target <= tg[i];
      conv({i[0], 1'b0, 3'(7 - i), 3'(i)}, 4'(i + 5));
    end
    // abort a slow manual conversion
    prev = {22'h0, tg[7]};
    target <= 10'h0AB;
    wr(OFS_TIMING, 32'h06);
    wr(OFS_CTRL, 32'h03);
    rchk(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h01);
    rchk(OFS_CTRL, 32'h1);
    repeat (11 * 64) @(posedge sys_clk);
    rchk(OFS_STATUS, 32'h0);
    rchk(OFS_RES_LOW, {24'h0, prev[7:0]});
    // reset in mid-conversion
    wr(OFS_CTRL, 32'h03);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk(converter_enable, 1'b0);
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_TIMING, 32'h0);
    rchk(OFS_RES_LOW, {24'h0, prev[7:0]});
    stop_test();
  end
endmodule : test_adc_acq_conv_ctrl
